// ### error_mask_and_eoi_pkg.sv
// Package with constants and types for the error mask and end-of-message block.
`default_nettype none
package error_mask_and_eoi_pkg;
  // Error register and mask width.
  localparam int ERR_W = 15;
  // Mask value at power-on and for a mask command without a value.
  localparam logic [14:0] MASK_ALL = 15'h7fff;
  // Value of a cleared error register.
  localparam logic [14:0] ERR_NONE = 15'h0000;
  // Error bit positions, each weight being two to the power of its position.
  localparam int ERR_HARDWARE = 0;
  localparam int ERR_CALIBRATION = 1;
  localparam int ERR_TRIG_FAST = 2;
  localparam int ERR_SYNTAX = 3;
  localparam int ERR_NOT_REMOTE = 4;
  localparam int ERR_UNDEF_PARAM = 5;
  localparam int ERR_OUT_RANGE = 6;
  localparam int ERR_MEMORY = 7;
  localparam int ERR_OVERLOAD = 8;
  localparam int ERR_OUT_OF_CAL = 9;
  localparam int ERR_CAL_REQUIRED = 10;
  localparam int ERR_SETTINGS = 11;
  localparam int ERR_MATH = 12;
  localparam int ERR_SUBPROGRAM = 13;
  localparam int ERR_SYSTEM = 14;
  // Position of the error bit in the status register.
  localparam int STATUS_ERR_BIT = 5;
  // Terminator and separator characters.
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [7:0] CHAR_COMMA = 8'h2c;
  // End-of-message modes with their numeric query codes.
  typedef enum logic [1:0] {
    EOI_OFF = 2'b00,
    EOI_ON = 2'b01,
    EOI_ALWAYS = 2'b10
  } eoiMode_t;
  // Separator sequencer states.
  typedef enum logic [1:0] {
    SEP_PASS = 2'b00,
    SEP_COMMA = 2'b01,
    SEP_CR = 2'b10,
    SEP_LF = 2'b11
  } sepState_t;
  // Context that travels with each reading byte.
  typedef struct packed {
    logic ascii;
    logic recall;
    logic multi;
    logic lastReading;
    logic highSpeed;
  } readingCtx_t;
  // One byte towards the bus with its end-or-identify flag.
  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } gpibByte_t;
endpackage
`default_nettype wire

// ### error_mask_and_eoi_control.sv
// Error enable mask, error register and end-of-message control for readings.
//
// Behaviour
// - Every error latches regardless of its mask bit.
// - Only enabled latched errors raise status bit five.
// - Error bit positions fixed: hardware zero, system fourteen.
// - Mask value loads weight per bit position.
// - Mask is all ones at reset, without value.
// - Mask query returns current mask.
// - Mode off never asserts end-or-identify.
// - Mode on marks only the sequence's last byte.
// - Mode always marks every reading's last byte.
// - Mode off at reset, always without parameter.
// - ASCII readings end with carriage return, line feed.
// - Non-ASCII readings carry no terminator.
// - Recalled ASCII groups: commas between, one terminator.
// - No commas outside ASCII memory recall.
// - Always mode acts as on during high speed.
// - Mode query returns the active mode.
// - Error query returns errors, then clears them.
`timescale 1ns/1ps
`default_nettype none
module error_mask_and_eoi_control
  import error_mask_and_eoi_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Error condition pulses, one bit per condition.
  input wire logic [14:0] errEvent,
  // Mask command and query.
  input wire logic maskWrite,
  input wire logic maskHasValue,
  input wire logic [14:0] maskValue,
  input wire logic maskQuery,
  // Error register query.
  input wire logic errQuery,
  // End-of-message mode command and query.
  input wire logic eoiWrite,
  input wire logic eoiHasValue,
  input wire logic [1:0] eoiValue,
  input wire logic eoiQuery,
  // Query answer.
  output logic replyValid,
  output logic [14:0] replyData,
  // Status register error bit.
  output logic statusErrBit,
  // Reading bytes in.
  input wire logic rdgValid,
  input wire logic [7:0] rdgData,
  input wire logic rdgLast,
  input wire readingCtx_t rdgCtx,
  output logic rdgReady,
  // Bytes out towards the bus.
  output logic gpibValid,
  output logic [7:0] gpibData,
  output logic gpibEoi,
  input wire logic gpibReady
);

  ////////////////////////////////////////////////////////////////////////////
  // Error register, mask and status bit.

  logic [14:0] errQ, errD; // Latched error conditions.
  logic [14:0] maskQ, maskD; // Error enable mask.
  logic statErrQ, statErrD; // Registered status error bit.

  // An event in the clearing cycle survives, since set wins over clear.
  always_comb begin
    errD = errQ;
    if (errQuery) begin
      errD = ERR_NONE;
    end
    errD = errD | errEvent;
    maskD = maskQ;
    if (maskWrite) begin
      // A bare command enables every condition.
      maskD = maskHasValue ? maskValue : MASK_ALL;
    end
    statErrD = |(errD & maskD);
  end

  // Registers for the error group.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errQ <= ERR_NONE;
      maskQ <= MASK_ALL;
      statErrQ <= 1'b0;
    end else begin
      errQ <= errD;
      maskQ <= maskD;
      statErrQ <= statErrD;
    end
  end

  assign statusErrBit = statErrQ;

  ////////////////////////////////////////////////////////////////////////////
  // End-of-message mode.

  eoiMode_t modeQ, modeD; // Programmed mode.
  eoiMode_t modeEff; // Mode in force now.

  // Illegal mode codes are ignored.
  always_comb begin
    modeD = modeQ;
    if (eoiWrite) begin
      if (!eoiHasValue) begin
        modeD = EOI_ALWAYS;
      end else if (eoiValue <= EOI_ALWAYS) begin
        modeD = eoiMode_t'(eoiValue);
      end
    end
  end

  // Mode register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeQ <= EOI_OFF;
    end else begin
      modeQ <= modeD;
    end
  end

  // High-speed readings see always as on, reverting only when rdgCtx.highSpeed drops.
  assign modeEff = (modeQ == EOI_ALWAYS && rdgCtx.highSpeed) ? EOI_ON : modeQ;

  ////////////////////////////////////////////////////////////////////////////
  // Query answer.

  logic replyValidQ, replyValidD; // Answer strobe.
  logic [14:0] replyDataQ, replyDataD; // Answer value.

  // Error query wins over mask query, which wins over mode query.
  always_comb begin
    replyValidD = errQuery | maskQuery | eoiQuery;
    replyDataD = replyDataQ;
    if (errQuery) begin
      replyDataD = errQ;
    end else if (maskQuery) begin
      replyDataD = maskQ;
    end else if (eoiQuery) begin
      replyDataD = {13'h0000, modeEff};
    end
  end

  // Answer registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      replyValidQ <= 1'b0;
      replyDataQ <= ERR_NONE;
    end else begin
      replyValidQ <= replyValidD;
      replyDataQ <= replyDataD;
    end
  end

  assign replyValid = replyValidQ;
  assign replyData = replyDataQ;

  ////////////////////////////////////////////////////////////////////////////
  // Reading byte stream with separators and end-or-identify.

  sepState_t sepQ, sepD; // Separator sequencer.
  readingCtx_t ctxQ, ctxD; // Context of the reading just ended.
  logic outValidQ, outValidD; // Output slot holds a byte.
  gpibByte_t outQ, outD; // Output byte.
  logic slotFree; // Output slot can take a byte.
  logic loadRdg; // A reading byte is taken.
  logic useComma; // Reading ends in a comma.

  // Decides the flag for a byte that ends a reading.
  function automatic logic eoiFor(eoiMode_t m, readingCtx_t c);
    logic seqEnd;
    seqEnd = !c.multi || c.lastReading;
    unique case (m)
      EOI_OFF: eoiFor = 1'b0;
      EOI_ON: eoiFor = seqEnd;
      EOI_ALWAYS: eoiFor = 1'b1;
      default: eoiFor = 1'b0;
    endcase
  endfunction

  assign slotFree = !outValidQ || gpibReady;
  assign rdgReady = (sepQ == SEP_PASS) && slotFree;
  assign loadRdg = rdgValid && rdgReady;
  assign useComma = rdgCtx.ascii && rdgCtx.recall && !rdgCtx.lastReading;

  // Next state of the stream.
  always_comb begin
    sepD = sepQ;
    ctxD = ctxQ;
    outD = outQ;
    outValidD = outValidQ && !gpibReady;
    unique case (sepQ)
      SEP_PASS: begin
        if (loadRdg) begin
          outValidD = 1'b1;
          outD.data = rdgData;
          outD.eoi = 1'b0;
          if (rdgLast) begin
            ctxD = rdgCtx;
            if (useComma) begin
              sepD = SEP_COMMA;
            end else if (rdgCtx.ascii) begin
              sepD = SEP_CR;
            end else begin
              outD.eoi = eoiFor(modeEff, rdgCtx);
            end
          end
        end
      end
      SEP_COMMA: begin
        if (slotFree) begin
          outValidD = 1'b1;
          outD.data = CHAR_COMMA;
          outD.eoi = eoiFor(modeEff, ctxQ);
          sepD = SEP_PASS;
        end
      end
      SEP_CR: begin
        if (slotFree) begin
          outValidD = 1'b1;
          outD.data = CHAR_CR;
          outD.eoi = 1'b0;
          sepD = SEP_LF;
        end
      end
      SEP_LF: begin
        if (slotFree) begin
          outValidD = 1'b1;
          outD.data = CHAR_LF;
          outD.eoi = eoiFor(modeEff, ctxQ);
          sepD = SEP_PASS;
        end
      end
    endcase
  end

  // Stream registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sepQ <= SEP_PASS;
      ctxQ <= '0;
      outValidQ <= 1'b0;
      outQ <= '0;
    end else begin
      sepQ <= sepD;
      ctxQ <= ctxD;
      outValidQ <= outValidD;
      outQ <= outD;
    end
  end

  assign gpibValid = outValidQ;
  assign gpibData = outQ.data;
  assign gpibEoi = outQ.eoi;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A final byte of a non-ASCII reading taken into the slot.
  sequence sBinEnd;
    loadRdg && rdgLast && !rdgCtx.ascii;
  endsequence

  // A final byte of an ASCII reading that takes a terminator.
  sequence sAsciiEnd;
    loadRdg && rdgLast && rdgCtx.ascii && !useComma;
  endsequence

  // Carriage return reaches the slot while the sequencer waits to send line feed.
  sequence sCrThenLf;
    (sepQ == SEP_CR) ##[1:20] (gpibValid && gpibData == CHAR_CR && sepQ == SEP_LF);
  endsequence

  a_err_latch: assert property ((|errEvent) |=> ((errQ & $past(errEvent)) == $past(errEvent)))
    else $error("Error event not latched");
  a_mask_block: assert property (statusErrBit |-> (|(errQ & maskQ)))
    else $error("Masked error raised status bit");
  a_stat_follow: assert property ((|(errQ & maskQ)) |-> statusErrBit)
    else $error("Status bit missing for enabled error");
  a_mask_load: assert property (maskWrite && maskHasValue |=> maskQ == $past(maskValue))
    else $error("Mask value not loaded");
  a_mask_default: assert property (maskWrite && !maskHasValue |=> maskQ == MASK_ALL)
    else $error("Bare mask command not all enabled");
  a_mask_reply: assert property (maskQuery && !errQuery |=> replyValid && replyData == $past(maskQ))
    else $error("Mask query answer wrong");
  a_err_clear: assert property (errQuery && errEvent == ERR_NONE |=> errQ == ERR_NONE && replyData == $past(errQ))
    else $error("Error query did not read and clear");
  a_eoi_off: assert property (loadRdg && modeEff == EOI_OFF |=> !gpibEoi)
    else $error("Flag asserted in off mode");
  a_eoi_always: assert property (sBinEnd and (modeEff == EOI_ALWAYS) |=> gpibEoi)
    else $error("Flag missing in always mode");
  a_eoi_on: assert property (sBinEnd and (modeEff == EOI_ON && rdgCtx.multi && !rdgCtx.lastReading) |=> !gpibEoi)
    else $error("Flag on inner reading in on mode");
  a_bin_noterm: assert property (sBinEnd |=> sepQ == SEP_PASS)
    else $error("Terminator after non-ASCII reading");
  a_ascii_term: assert property (sAsciiEnd |=> sCrThenLf)
    else $error("Terminator pair not sent");
  a_comma_ins: assert property (loadRdg && rdgLast && useComma |=> sepQ == SEP_COMMA)
    else $error("Comma not inserted in recall");
  a_no_comma: assert property (loadRdg && rdgLast && !rdgCtx.recall |=> sepQ != SEP_COMMA)
    else $error("Comma outside memory recall");
  a_high_speed: assert property (modeQ == EOI_ALWAYS && rdgCtx.highSpeed |-> modeEff == EOI_ON)
    else $error("High speed did not force on mode");
  a_mode_reply: assert property (eoiQuery && !errQuery && !maskQuery |=> replyData[1:0] == $past(modeEff))
    else $error("Mode query answer wrong");
  a_mode_bare: assert property (eoiWrite && !eoiHasValue |=> modeQ == EOI_ALWAYS)
    else $error("Bare mode command not always");

endmodule // error_mask_and_eoi_control
`default_nettype wire

// ### gpib_sink_model.sv
// Behavioural bus controller that accepts bytes from the block and records them.
`timescale 1ns/1ps
`default_nettype none
module gpib_sink_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Byte stream from the block.
  input wire logic gpibValid,
  input wire logic [7:0] gpibData,
  input wire logic gpibEoi,
  output logic gpibReady,
  // Stall control from the bench.
  input wire logic slow
);
  // Received bytes, each as data and end flag.
  logic [8:0] rxQ[$];
  initial gpibReady = 1'h0;
  // Takes a byte on each edge with valid and ready high, then updates ready.
  // When slow, ready toggles every cycle, so the block must hold its byte.
  always @(posedge clk) begin
    if (rst_n && gpibValid === 1'h1 && gpibReady) begin
      rxQ.push_back({gpibData, gpibEoi});
    end
    #1 gpibReady = rst_n && (!slow || !gpibReady);
  end
endmodule // gpib_sink_model
`default_nettype wire

// ### error_mask_and_eoi_control_tb.sv
// Self-checking testbench for the error mask and end-of-message block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module error_mask_and_eoi_control_tb;
  import error_mask_and_eoi_pkg::*;
  // Stimulus and observed signals.
  logic clk = 1'h0, rst_n = 1'h0, slow = 1'h0;
  logic [14:0] errEvent = 15'h0, maskValue = 15'h0, replyData;
  logic maskWrite = 1'h0, maskHasValue = 1'h0, maskQuery = 1'h0, errQuery = 1'h0;
  logic eoiWrite = 1'h0, eoiHasValue = 1'h0, eoiQuery = 1'h0, replyValid, statusErrBit;
  logic [1:0] eoiValue = 2'h0;
  logic rdgValid = 1'h0, rdgLast = 1'h0, rdgReady, gpibValid, gpibEoi, gpibReady;
  logic [7:0] rdgData = 8'h0, gpibData;
  readingCtx_t rdgCtx = 5'h0;
  logic [8:0] expQ[$];
  int err_count = 0, tests_run = 0;
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  error_mask_and_eoi_control error_mask_and_eoi_control_inst (.clk, .rst_n, .errEvent, .maskWrite,
    .maskHasValue, .maskValue, .maskQuery, .errQuery, .eoiWrite, .eoiHasValue, .eoiValue, .eoiQuery,
    .replyValid, .replyData, .statusErrBit, .rdgValid, .rdgData, .rdgLast, .rdgCtx, .rdgReady,
    .gpibValid, .gpibData, .gpibEoi, .gpibReady);
  gpib_sink_model gpib_sink_model_inst (.clk, .rst_n, .gpibValid, .gpibData, .gpibEoi, .gpibReady, .slow);
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Moves to just after the next rising edge.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Issues a query (0 error, 1 mask, 2 mode) and compares the answer.
  task automatic query(input int k, input logic [14:0] expv);
    errQuery = (k == 0);
    maskQuery = (k == 1);
    eoiQuery = (k == 2);
    tick();
    errQuery = 1'h0;
    maskQuery = 1'h0;
    eoiQuery = 1'h0;
    `CHK(replyValid, 1'h1)
    `CHK(replyData, expv)
    // Lets an edge pass, so a following strobe rises in a later step; the answer strobe lasts one cycle.
    tick();
    `CHK(replyValid, 1'h0)
  endtask
  // Mask command, with or without a value.
  task automatic setMask(input logic h, input logic [14:0] val);
    maskWrite = 1'h1;
    maskHasValue = h;
    maskValue = val;
    tick();
    maskWrite = 1'h0;
  endtask
  // Mode command, with or without a value.
  task automatic setMode(input logic h, input logic [1:0] val);
    eoiWrite = 1'h1;
    eoiHasValue = h;
    eoiValue = val;
    tick();
    eoiWrite = 1'h0;
  endtask
  // One-cycle error pulse.
  task automatic pulseErr(input logic [14:0] val);
    errEvent = val;
    tick();
    errEvent = 15'h0;
    // Lets an edge pass, so a following pulse rises in a later step.
    tick();
  endtask
  // Offers one reading byte and holds it until the block takes it.
  task automatic put(input logic [7:0] d, input logic l, input readingCtx_t c);
    int k;
    rdgValid = 1'h1;
    rdgData = d;
    rdgLast = l;
    rdgCtx = c;
    for (k = 0; k < 20; k++) begin
      @(negedge clk);
      if (rdgReady === 1'h1) break;
    end
    if (k == 20) begin
      err_count++;
      summarize();
    end
    tick();
  endtask
  // Sends one reading of n bytes and compares the bus bytes with the expected stream.
  task automatic reading(input int n, input readingCtx_t c, input eoiMode_t m);
    logic e;
    int k;
    e = (m == EOI_ALWAYS && !c.highSpeed) ||
        ((m == EOI_ON || (m == EOI_ALWAYS && c.highSpeed)) && (!c.multi || c.lastReading));
    gpib_sink_model_inst.rxQ.delete();
    expQ.delete();
    for (k = 0; k < n; k++) begin
      put(8'h30 + 8'(k), k == n - 1, c);
      expQ.push_back({8'h30 + 8'(k), 1'h0});
    end
    rdgValid = 1'h0;
    // A pending comma or terminator pair must hold off the next reading byte.
    if (c.ascii) `CHK(rdgReady, 1'h0)
    // Non-ASCII marks its own last byte; ASCII appends a comma or the terminator pair.
    if (!c.ascii) begin
      expQ[n - 1][0] = e;
    end else if (c.recall && !c.lastReading) begin
      expQ.push_back({CHAR_COMMA, e});
    end else begin
      expQ.push_back({CHAR_CR, 1'h0});
      expQ.push_back({CHAR_LF, e});
    end
    for (k = 0; k < 40 && gpib_sink_model_inst.rxQ.size() < expQ.size(); k++) tick();
    if (k == 40) begin
      err_count++;
      summarize();
    end
    repeat (2) tick();
    `CHK(gpib_sink_model_inst.rxQ.size(), expQ.size())
    for (k = 0; k < expQ.size(); k++) `CHK(gpib_sink_model_inst.rxQ[k], expQ[k])
    `CHK(rdgReady, 1'h1)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values of mask, mode and status bit.
  task automatic t_reset();
    query(1, MASK_ALL);
    query(2, 15'h0);
    `CHK(statusErrBit, 1'h0)
    $display("test reset done");
  endtask
  // Masking, latching and clearing of errors.
  task automatic t_mask();
    setMask(1'h1, 15'h0004);
    query(1, 15'h0004);
    pulseErr(15'h0008);
    `CHK(statusErrBit, 1'h0)
    query(0, 15'h0008);
    query(0, 15'h0);
    setMask(1'h1, 15'h00f8);
    pulseErr(15'h0080);
    `CHK(statusErrBit, 1'h1)
    query(0, 15'h0080);
    `CHK(statusErrBit, 1'h0)
    setMask(1'h0, 15'h0001);
    query(1, MASK_ALL);
    setMask(1'h1, 15'h0);
    query(1, 15'h0);
    $display("test mask done");
  endtask
  // Every error position against its own mask bit.
  task automatic t_bits();
    for (int i = 0; i < ERR_W; i++) begin
      setMask(1'h1, 15'h1 << i);
      pulseErr(~(15'h1 << i));
      `CHK(statusErrBit, 1'h0)
      pulseErr(15'h1 << i);
      `CHK(statusErrBit, 1'h1)
      query(0, 15'h7fff);
    end
    $display("test bits done");
  endtask
  // End-of-message modes, terminators and separators.
  task automatic t_stream();
    reading(3, 5'h10, EOI_OFF);
    setMode(1'h1, 2'h1);
    reading(2, 5'h14, EOI_ON);
    reading(2, 5'h16, EOI_ON);
    setMode(1'h1, 2'h3);
    query(2, 15'h1);
    setMode(1'h0, 2'h0);
    query(2, 15'h2);
    reading(2, 5'h14, EOI_ALWAYS);
    slow = 1'h1;
    reading(3, 5'h04, EOI_ALWAYS);
    slow = 1'h0;
    setMode(1'h1, 2'h1);
    reading(2, 5'h0c, EOI_ON);
    reading(1, 5'h06, EOI_ON);
    reading(2, 5'h1c, EOI_ON);
    reading(1, 5'h1e, EOI_ON);
    setMode(1'h1, 2'h2);
    reading(2, 5'h15, EOI_ALWAYS);
    query(2, 15'h1);
    rdgCtx = 5'h0;
    query(2, 15'h2);
    $display("test stream done");
  endtask
  // Main sequence: reset for two cycles, then the scenarios.
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'h1;
    t_reset();
    t_mask();
    t_bits();
    t_stream();
    summarize();
  end
endmodule // error_mask_and_eoi_control_tb
`default_nettype wire
